/* File: pkg/lab_pkg.sv */
/*
 * Shared constants for the break addressing logic of one serial line adaptor:
 * register map, field positions, reset values and the break sequence states.
 * Assumes a single clock domain and a zero-wait AHB-Lite slave port.
 */
// Contract
// [R01] Only granted adaptor drives shared busses
// [R02] Request pulls line low; grant selects
// [R03] Set request flop, then await grant
// [R04] Drive transfer direction during granted break
// [R05] Address-accepted pulse clears break request
// [R06] Break state, select, pulse one: done
// [R07] Host writes input lines into core
// [R08] Request on text overflow, transmit entry
// [R09] Data register on input lines when selected
// [R10] Low bit zero receive, one transmit
// [R11] Scanner drives page while enable low
// [R12] Card sets three bits above lowest
// [R13] Cable block number on positions five-seven
// [R14] Granted: drive block, pull page enable
// [R15] Scanner polls lines, stops on interrupt
// [R16] Scan address holds interrupting buffer address
// [R17] Software loads scan address to select
// [R18] Match only when scan equals assigned
// [R19] Each moved character sets service flag
// [R20] Power clear drops request and done
package lab_pkg;

   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] CONTROL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] DATA_OFFSET = 8'h08;
   localparam logic [7:0] ADDRESS_OFFSET = 8'h0c;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int CONTROL_ENABLE_BIT = 0;
   localparam int STATUS_REQUEST_BIT = 0;
   localparam int STATUS_SERVICE_BIT = 1;
   localparam int STATUS_GRANT_BIT = 2;
   localparam int STATUS_MATCH_BIT = 3;
   localparam int STATUS_DIRECTION_BIT = 4;
   localparam int STATUS_BUSY_BIT = 5;

   // ************************************************************
   // Widths and reset values
   // ************************************************************
   localparam int WORD_WIDTH = 12;
   localparam int LOCAL_ADDR_WIDTH = 7;
   localparam logic CONTROL_ENABLE_RESET = 1'b0;
   localparam logic [11:0] DATA_RESET = 12'h000;
   localparam logic DIR_INTO_CORE = 1'b1;
   localparam logic BUFFER_RECEIVE = 1'b0;
   localparam logic BUFFER_TRANSMIT = 1'b1;

   // ************************************************************
   // Break sequence states
   // ************************************************************
   typedef enum logic [1:0] {
      BREAK_IDLE = 2'b00,
      BREAK_REQUEST = 2'b01,
      BREAK_WAIT_DONE = 2'b10
   } lab_state_type;

endpackage

/* File: rtl/lab_break_ctrl.sv */
/*
 * Break request and address generation for one serial line adaptor, with
 * an AHB-Lite register slave for control, status and the serial data word.
 * Assumes the break multiplexor, scanner and host are synchronous to MCLK
 * and that BREAK_GRANT is the adaptor's own decoded select.
 */
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module lab_break_ctrl (
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic POWER_CLEAR_PULSE,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic HRESP,
   output logic [31:0] HRDATA,
   input wire logic BREAK_GRANT,
   input wire logic HOST_BREAK_STATE,
   input wire logic BREAK_TIME_PULSE_ONE,
   input wire logic ADDRESS_ACCEPTED,
   input wire logic [11:0] MEMORY_BUFFER,
   input wire logic [11:0] SCAN_ADDRESS,
   input wire logic [2:0] BLOCK_NUMBER,
   input wire logic [2:0] ADDRESS_CARD,
   input wire logic FRAME_OVERFLOW,
   input wire logic TEXT_STATE,
   input wire logic TRANSMIT_STATE,
   output logic BREAK_REQUEST_N,
   output logic TRANSFER_DIRECTION_O,
   output logic TRANSFER_DIRECTION_OE,
   output logic [11:0] BREAK_INPUT_LINES_O,
   output logic BREAK_INPUT_LINES_OE,
   output logic [6:0] DATA_ADDR_O,
   output logic DATA_ADDR_OE,
   output logic PAGE_ADDRESS_ENABLE_N_O,
   output logic PAGE_ADDRESS_ENABLE_N_OE,
   output logic BREAK_DONE_PULSE,
   output logic CHAR_SERVICE_FLAG,
   output logic SCAN_MATCH
);

   // ************************************************************
   // Helpers
   // ************************************************************
   // Local part of a buffer address: block, card position, buffer bit.
   function automatic logic [6:0] local_addr(input logic [2:0] blk,
                                             input logic [2:0] card,
                                             input logic buf_bit);
      local_addr = {blk, card, buf_bit};
   endfunction

   // ************************************************************
   // Declarations
   // ************************************************************
   lab_pkg::lab_state_type state;
   lab_pkg::lab_state_type next_state;
   logic direction;
   logic next_direction;
   logic [11:0] serial_data_register;
   logic [11:0] next_serial_data_register;
   logic char_service_flag;
   logic next_char_service_flag;
   logic control_enable;
   logic next_control_enable;
   logic transmit_seen;
   logic next_transmit_seen;
   logic [6:0] break_addr;
   logic [6:0] next_break_addr;
   logic scan_match;
   logic next_scan_match;
   logic bus_write_pending;
   logic next_bus_write_pending;
   logic [7:0] bus_addr;
   logic [7:0] next_bus_addr;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic break_select;
   logic break_request_ff;
   logic break_done;
   logic text_trigger;
   logic transmit_trigger;
   logic bus_take;
   logic write_data;
   logic write_control;
   logic clear_service;

   // ************************************************************
   // Break sequence
   // ************************************************************
   // [R02] grant is the select
   assign break_select = BREAK_GRANT;
   assign break_request_ff = (state == lab_pkg::BREAK_REQUEST);

   // [R08] text overflow trigger
   assign text_trigger = FRAME_OVERFLOW && TEXT_STATE;
   // [R08] transmit entry trigger
   assign transmit_trigger = TRANSMIT_STATE && !transmit_seen;

   // [R06] done on first pulse
   assign break_done = (state == lab_pkg::BREAK_WAIT_DONE) && HOST_BREAK_STATE
                       && break_select && BREAK_TIME_PULSE_ONE;

   always_comb begin
      next_state = state;
      next_direction = direction;
      next_transmit_seen = TRANSMIT_STATE;
      unique case (state)
         lab_pkg::BREAK_IDLE: begin
            // [R03] set request flop
            if (control_enable && (text_trigger || transmit_trigger)) begin
               next_state = lab_pkg::BREAK_REQUEST;
               // [R10] receive goes into core
               next_direction = TRANSMIT_STATE ? !lab_pkg::DIR_INTO_CORE
                                               : lab_pkg::DIR_INTO_CORE;
            end
         end
         lab_pkg::BREAK_REQUEST: begin
            // [R05] drop request on accept
            if (ADDRESS_ACCEPTED && break_select) begin
               next_state = lab_pkg::BREAK_WAIT_DONE;
            end
         end
         lab_pkg::BREAK_WAIT_DONE: begin
            if (break_done) begin
               next_state = lab_pkg::BREAK_IDLE;
            end
         end
         default: begin
            next_state = lab_pkg::BREAK_IDLE;
         end
      endcase
      // [R20] power clear drops request and done
      if (POWER_CLEAR_PULSE) begin
         next_state = lab_pkg::BREAK_IDLE;
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         state <= lab_pkg::BREAK_IDLE;
         direction <= lab_pkg::DIR_INTO_CORE;
         transmit_seen <= 1'b0;
      end else begin
         state <= next_state;
         direction <= next_direction;
         transmit_seen <= next_transmit_seen;
      end
   end

   // ************************************************************
   // Data word, service flag and addressing
   // ************************************************************
   always_comb begin
      next_serial_data_register = serial_data_register;
      next_char_service_flag = char_service_flag;
      if (write_data) begin
         next_serial_data_register = HWDATA[11:0];
      end
      // [R06] done loads memory word
      if (break_done) begin
         next_serial_data_register = MEMORY_BUFFER;
      end
      if (clear_service) begin
         next_char_service_flag = 1'b0;
      end
      // [R19] moved character sets flag
      if (break_done) begin
         next_char_service_flag = 1'b1;
      end
      // [R12] card bits
      // [R13] block from cable
      next_break_addr = local_addr(BLOCK_NUMBER, ADDRESS_CARD,
                                   direction == lab_pkg::DIR_INTO_CORE ?
                                   lab_pkg::BUFFER_RECEIVE : lab_pkg::BUFFER_TRANSMIT);
      // [R18] match assigned address
      next_scan_match = (SCAN_ADDRESS[6:1] == {BLOCK_NUMBER, ADDRESS_CARD});
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         serial_data_register <= lab_pkg::DATA_RESET;
         char_service_flag <= 1'b0;
         break_addr <= '0;
         scan_match <= 1'b0;
      end else begin
         serial_data_register <= next_serial_data_register;
         char_service_flag <= next_char_service_flag;
         break_addr <= next_break_addr;
         scan_match <= next_scan_match;
      end
   end

   // ************************************************************
   // Register slave
   // ************************************************************
   // Zero wait states: read data is fetched in the address phase so that it
   // stands from a flop through the whole data phase.
   assign bus_take = HSEL && HTRANS[1] && HREADY;
   assign write_data = bus_write_pending && (bus_addr == lab_pkg::DATA_OFFSET);
   assign write_control = bus_write_pending && (bus_addr == lab_pkg::CONTROL_OFFSET);
   assign clear_service = bus_write_pending && (bus_addr == lab_pkg::STATUS_OFFSET)
                          && HWDATA[lab_pkg::STATUS_SERVICE_BIT];

   always_comb begin
      next_bus_write_pending = bus_take && HWRITE;
      next_bus_addr = bus_take ? HADDR[7:0] : bus_addr;
      next_control_enable = control_enable;
      next_rdata = 32'h0000_0000;
      if (write_control) begin
         next_control_enable = HWDATA[lab_pkg::CONTROL_ENABLE_BIT];
      end
      if (bus_take && !HWRITE) begin
         unique case (HADDR[7:0])
            lab_pkg::CONTROL_OFFSET: begin
               next_rdata[lab_pkg::CONTROL_ENABLE_BIT] = control_enable;
            end
            lab_pkg::STATUS_OFFSET: begin
               next_rdata[lab_pkg::STATUS_REQUEST_BIT] = break_request_ff;
               next_rdata[lab_pkg::STATUS_SERVICE_BIT] = char_service_flag;
               next_rdata[lab_pkg::STATUS_GRANT_BIT] = break_select;
               next_rdata[lab_pkg::STATUS_MATCH_BIT] = scan_match;
               next_rdata[lab_pkg::STATUS_DIRECTION_BIT] = direction;
               next_rdata[lab_pkg::STATUS_BUSY_BIT] = (state != lab_pkg::BREAK_IDLE);
            end
            lab_pkg::DATA_OFFSET: begin
               next_rdata[11:0] = serial_data_register;
            end
            lab_pkg::ADDRESS_OFFSET: begin
               next_rdata[6:0] = break_addr;
            end
            default: begin
               next_rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         bus_write_pending <= 1'b0;
         bus_addr <= 8'h00;
         control_enable <= lab_pkg::CONTROL_ENABLE_RESET;
         rdata <= 32'h0000_0000;
      end else begin
         bus_write_pending <= next_bus_write_pending;
         bus_addr <= next_bus_addr;
         control_enable <= next_control_enable;
         rdata <= next_rdata;
      end
   end

   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign HRDATA = rdata;

   // ************************************************************
   // Pins
   // ************************************************************
   // [R02] request pulls line low
   assign BREAK_REQUEST_N = !break_request_ff;
   // [R04] direction while granted
   assign TRANSFER_DIRECTION_O = direction;
   // [R01] shared busses only when selected
   assign TRANSFER_DIRECTION_OE = break_select;
   // [R09] data lines while selected
   assign BREAK_INPUT_LINES_O = serial_data_register;
   assign BREAK_INPUT_LINES_OE = break_select;
   // [R14] block address and page enable
   assign DATA_ADDR_O = break_addr;
   assign DATA_ADDR_OE = break_select;
   assign PAGE_ADDRESS_ENABLE_N_O = 1'b0;
   assign PAGE_ADDRESS_ENABLE_N_OE = break_select;
   assign BREAK_DONE_PULSE = break_done;
   assign CHAR_SERVICE_FLAG = char_service_flag;
   assign SCAN_MATCH = scan_match;

endmodule

/* File: test/lab_break_chk.sv */
/* Pin checks for the break controller.
   Assumes one MCLK domain; bound onto every lab_break_ctrl. */
`timescale 1ns/10ps
module lab_break_chk (
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic POWER_CLEAR_PULSE,
   input wire logic BREAK_GRANT,
   input wire logic HOST_BREAK_STATE,
   input wire logic BREAK_TIME_PULSE_ONE,
   input wire logic ADDRESS_ACCEPTED,
   input wire logic [11:0] MEMORY_BUFFER,
   input wire logic [11:0] SCAN_ADDRESS,
   input wire logic [2:0] BLOCK_NUMBER,
   input wire logic [2:0] ADDRESS_CARD,
   input wire logic BREAK_REQUEST_N,
   input wire logic TRANSFER_DIRECTION_O,
   input wire logic TRANSFER_DIRECTION_OE,
   input wire logic [11:0] BREAK_INPUT_LINES_O,
   input wire logic BREAK_INPUT_LINES_OE,
   input wire logic [6:0] DATA_ADDR_O,
   input wire logic DATA_ADDR_OE,
   input wire logic PAGE_ADDRESS_ENABLE_N_O,
   input wire logic PAGE_ADDRESS_ENABLE_N_OE,
   input wire logic BREAK_DONE_PULSE,
   input wire logic CHAR_SERVICE_FLAG,
   input wire logic SCAN_MATCH
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (SRST);
   a_data_gate: assert property (BREAK_INPUT_LINES_OE == BREAK_GRANT)
      else $error("data lines enable differs from grant");
   a_bus_gates: assert property (DATA_ADDR_OE == BREAK_GRANT &&
      PAGE_ADDRESS_ENABLE_N_OE == BREAK_GRANT && TRANSFER_DIRECTION_OE == BREAK_GRANT)
      else $error("bus enable differs from grant");
   a_page_low: assert property (PAGE_ADDRESS_ENABLE_N_OE |-> !PAGE_ADDRESS_ENABLE_N_O)
      else $error("page enable not pulled low");
   a_done_cause: assert property (BREAK_DONE_PULSE |-> (BREAK_GRANT && HOST_BREAK_STATE &&
      BREAK_TIME_PULSE_ONE) ##1 (BREAK_INPUT_LINES_O == $past(MEMORY_BUFFER) && CHAR_SERVICE_FLAG))
      else $error("break done cause or load wrong");
   a_request_holds: assert property (!BREAK_REQUEST_N && !POWER_CLEAR_PULSE &&
      !(ADDRESS_ACCEPTED && BREAK_GRANT) |=> !BREAK_REQUEST_N)
      else $error("request dropped early");
   a_accept_drops: assert property (!BREAK_REQUEST_N && ADDRESS_ACCEPTED && BREAK_GRANT
      |=> BREAK_REQUEST_N) else $error("request kept after accept");
   a_clear_idles: assert property (POWER_CLEAR_PULSE |=> BREAK_REQUEST_N && !BREAK_DONE_PULSE)
      else $error("power clear left a request");
   a_addr_fields: assert property (!$past(SRST) |->
      DATA_ADDR_O[6:1] == $past({BLOCK_NUMBER, ADDRESS_CARD})) else $error("address fields wrong");
   a_low_bit: assert property (DATA_ADDR_OE && $past(DATA_ADDR_OE) |->
      DATA_ADDR_O[0] != TRANSFER_DIRECTION_O) else $error("buffer bit against direction");
   a_match_decode: assert property (!$past(SRST) |-> SCAN_MATCH ==
      ($past(SCAN_ADDRESS[6:1]) == $past({BLOCK_NUMBER, ADDRESS_CARD})))
      else $error("scan match wrong");
endmodule
bind lab_break_ctrl lab_break_chk u_chk (.*);

/* File: test/lab_host_model.sv */
/* Host break multiplexor model for one adaptor.
   Assumes the bench sets WAIT_CYC and WORD before each request. */
`timescale 1ns/10ps
module lab_host_model (
   input wire logic MCLK,
   input wire logic BREAK_REQUEST_N,
   input wire logic TRANSFER_DIRECTION_O,
   input wire logic [11:0] BREAK_INPUT_LINES_O,
   input wire logic [3:0] WAIT_CYC,
   input wire logic [11:0] WORD,
   output logic BREAK_GRANT,
   output logic HOST_BREAK_STATE,
   output logic BREAK_TIME_PULSE_ONE,
   output logic ADDRESS_ACCEPTED,
   output logic [11:0] MEMORY_BUFFER,
   output logic [11:0] CORE_WORD
);
   initial begin
      {BREAK_GRANT, HOST_BREAK_STATE, BREAK_TIME_PULSE_ONE, ADDRESS_ACCEPTED} = 4'h0;
      MEMORY_BUFFER = 12'h5a5;
      CORE_WORD = 12'h000;
      forever begin
         @(posedge MCLK);
         // Outside a break the word toggles, so a stale sample cannot pass.
         if (BREAK_REQUEST_N !== 1'b0) MEMORY_BUFFER <= ~MEMORY_BUFFER;
         else begin
            repeat (WAIT_CYC) @(posedge MCLK);
            if (BREAK_REQUEST_N !== 1'b0) continue;
            {BREAK_GRANT, HOST_BREAK_STATE} <= 2'b11;
            MEMORY_BUFFER <= WORD;
            @(posedge MCLK);
            ADDRESS_ACCEPTED <= 1'b1;
            @(posedge MCLK);
            ADDRESS_ACCEPTED <= 1'b0;
            BREAK_TIME_PULSE_ONE <= 1'b1;
            @(posedge MCLK);
            if (TRANSFER_DIRECTION_O === lab_pkg::DIR_INTO_CORE) CORE_WORD <= BREAK_INPUT_LINES_O;
            {BREAK_GRANT, HOST_BREAK_STATE, BREAK_TIME_PULSE_ONE} <= 3'h0;
         end
      end
   end
endmodule

/* File: test/tb.sv */
/* Self-checking bench: AHB-Lite master, random breaks, host model.
   Assumes the slave answers with zero wait states. */
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
   $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb;
   logic MCLK, SRST, POWER_CLEAR_PULSE, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, tx;
   logic [31:0] HADDR, HWDATA, HRDATA, q;
   logic [1:0] HTRANS;
   logic [2:0] HSIZE, BLOCK_NUMBER, ADDRESS_CARD;
   logic BREAK_GRANT, HOST_BREAK_STATE, BREAK_TIME_PULSE_ONE, ADDRESS_ACCEPTED;
   logic [11:0] MEMORY_BUFFER, SCAN_ADDRESS, BREAK_INPUT_LINES_O, WORD, CORE_WORD, prev;
   logic FRAME_OVERFLOW, TEXT_STATE, TRANSMIT_STATE, BREAK_REQUEST_N, TRANSFER_DIRECTION_O;
   logic TRANSFER_DIRECTION_OE, BREAK_INPUT_LINES_OE, DATA_ADDR_OE, PAGE_ADDRESS_ENABLE_N_O;
   logic PAGE_ADDRESS_ENABLE_N_OE, BREAK_DONE_PULSE, CHAR_SERVICE_FLAG, SCAN_MATCH;
   logic [6:0] DATA_ADDR_O;
   logic [3:0] WAIT_CYC;
   logic [15:0] lf = 16'h0007;
   int fails = 0;
   int checks = 0;
   int cyc = 0;
   int n;
   assign HREADY = HREADYOUT;
   // The scanner adds the page while the enable line is pulled low.
   logic [11:0] full_addr;
   assign full_addr = (PAGE_ADDRESS_ENABLE_N_OE && !PAGE_ADDRESS_ENABLE_N_O) ?
                      {SCAN_ADDRESS[11:7], DATA_ADDR_O} : 12'h000;
   lab_break_ctrl u_dut (.*);
   lab_host_model u_host (.*);
   function automatic logic [15:0] step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [31:0] exp_addr(input logic [2:0] b, c, input logic t);
      return {25'h0, b, c, t};
   endfunction
   function automatic logic [31:0] exp_status(input logic r, m, b);
      exp_status = 32'h0;
      exp_status[lab_pkg::STATUS_REQUEST_BIT] = r;
      exp_status[lab_pkg::STATUS_MATCH_BIT] = m;
      exp_status[lab_pkg::STATUS_BUSY_BIT] = b;
   endfunction
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge MCLK);
      {HSEL, HWRITE, HTRANS, HADDR} <= {1'b1, w, 2'b10, 24'h0, a};
      do @(posedge MCLK); while (HREADY !== 1'b1);
      {HSEL, HTRANS, HWDATA} <= {1'b0, 2'b00, d};
      do @(posedge MCLK); while (HREADY !== 1'b1);
      q = HRDATA;
   endtask
   task automatic wrap_up();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      MCLK = 1'b0;
      forever #20 MCLK = ~MCLK;
   end
   always @(posedge MCLK) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         wrap_up();
      end
   end
   initial begin
      {SRST, POWER_CLEAR_PULSE, HSEL, HWRITE, FRAME_OVERFLOW, TEXT_STATE, TRANSMIT_STATE} = 7'h40;
      {HTRANS, HSIZE, HADDR, HWDATA, BLOCK_NUMBER, ADDRESS_CARD} = {5'h02, 70'h0};
      {SCAN_ADDRESS, WORD, WAIT_CYC, prev} = 40'h0;
      repeat (20) @(posedge MCLK);
      SRST <= 1'b0;
      bus(0, lab_pkg::DATA_OFFSET, 0);
      `CHK("data reset", 32'h0, q)
      bus(0, 8'h10, 0);
      `CHK("unmapped", 32'h0, q)
      `CHK("resp", 1'b0, HRESP)
      // Disabled adaptor must ignore a transmit entry.
      TRANSMIT_STATE <= 1'b1;
      repeat (4) @(posedge MCLK);
      `CHK("request off", 1'b1, BREAK_REQUEST_N)
      TRANSMIT_STATE <= 1'b0;
      bus(1, lab_pkg::CONTROL_OFFSET, 1);
      bus(0, lab_pkg::CONTROL_OFFSET, 0);
      `CHK("enable", 32'h1, q)
      {WAIT_CYC, TRANSMIT_STATE} <= 5'h1f;
      repeat (3) @(posedge MCLK);
      `CHK("request on", 1'b0, BREAK_REQUEST_N)
      bus(0, lab_pkg::STATUS_OFFSET, 0);
      `CHK("status pending", exp_status(1'b1, 1'b1, 1'b1), q)
      POWER_CLEAR_PULSE <= 1'b1;
      @(posedge MCLK);
      POWER_CLEAR_PULSE <= 1'b0;
      repeat (2) @(posedge MCLK);
      `CHK("request clear", 1'b1, BREAK_REQUEST_N)
      TRANSMIT_STATE <= 1'b0;
      repeat (20) @(posedge MCLK);
      for (int i = 0; i < 10; i++) begin
         lf = step(lf);
         tx = lf[0];
         @(posedge MCLK);
         {BLOCK_NUMBER, ADDRESS_CARD, WORD} <= {lf[6:1], lf[15:4]};
         WAIT_CYC <= (i == 0) ? 4'h0 : lf[11:8];
         SCAN_ADDRESS <= {lf[15:11], lf[6:1], tx};
         {TEXT_STATE, FRAME_OVERFLOW, TRANSMIT_STATE} <= {!tx, !tx, tx};
         @(posedge MCLK);
         FRAME_OVERFLOW <= 1'b0;
         n = 0;
         while (BREAK_DONE_PULSE !== 1'b1 && n < 40) begin
            @(posedge MCLK);
            n++;
         end
         `CHK("done", 1'b1, BREAK_DONE_PULSE)
         `CHK("break address", {lf[15:11], lf[6:1], tx}, full_addr)
         {TEXT_STATE, TRANSMIT_STATE} <= 2'b00;
         bus(0, lab_pkg::DATA_OFFSET, 0);
         `CHK("data", {20'h0, lf[15:4]}, q)
         bus(0, lab_pkg::ADDRESS_OFFSET, 0);
         `CHK("address", exp_addr(lf[6:4], lf[3:1], tx), q)
         bus(0, lab_pkg::STATUS_OFFSET, 0);
         `CHK("service", 1'b1, q[lab_pkg::STATUS_SERVICE_BIT])
         `CHK("match", 1'b1, SCAN_MATCH)
         if (!tx) `CHK("core", prev, CORE_WORD)
         prev = lf[15:4];
         bus(1, lab_pkg::STATUS_OFFSET, 32'h2);
         SCAN_ADDRESS[1] <= ~SCAN_ADDRESS[1];
         repeat (2) @(posedge MCLK);
         `CHK("no match", 1'b0, SCAN_MATCH)
         `CHK("service clear", 1'b0, CHAR_SERVICE_FLAG)
         // poll the block, stop at own card
         for (int k = 0; k < 8; k++) begin
            SCAN_ADDRESS[6:1] <= {lf[6:4], k[2:0]};
            repeat (2) @(posedge MCLK);
            `CHK("poll match", (k[2:0] == lf[3:1]), SCAN_MATCH)
            if (SCAN_MATCH === 1'b1) break;
         end
      end
      wrap_up();
   end
endmodule
